// ---- inc/cmc_pkg.sv ----
// cmc_pkg: constants, register map and field layout of converter mode control
// assumes a 100 MHz core clock and a 32-bit apb register bus
package cmc_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] CMC_OFS_CONFIG    = 12'h000;
	localparam logic [11:0] CMC_OFS_RANGE_I   = 12'h00c;
	localparam logic [11:0] CMC_OFS_RANGE_Q   = 12'h02c;
	localparam logic [11:0] CMC_OFS_STATUS    = 12'h040;
	// ----------------------------------------------------------------
	// config register fields
	// ----------------------------------------------------------------
	localparam int CMC_BIT_TRIM        = 1;
	localparam int CMC_BIT_ALT_INPUT   = 6;
	localparam int CMC_BIT_INTERLEAVE  = 7;
	localparam int CMC_BIT_SLEEP_Q     = 10;
	localparam int CMC_BIT_SLEEP_I     = 11;
	localparam int CMC_BIT_PATTERN     = 12;
	localparam int CMC_BIT_PHASE       = 14;
	localparam logic [31:0] CMC_CONFIG_MASK  = 32'h0000_5cc2;
	localparam logic [31:0] CMC_CONFIG_RESET = 32'h0000_0000;
	localparam int CMC_RANGE_W = 8;
	localparam logic [7:0] CMC_RANGE_RESET = 8'h00;
	localparam logic [7:0] CMC_RANGE_MIN   = 8'h00;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CMC_CLK_MHZ          = 100;
	localparam int CMC_TRIM_LOW_NS      = 80;
	localparam int CMC_TRIM_HIGH_NS     = 80;
	localparam int CMC_TRIM_LOW_CYC     = (CMC_TRIM_LOW_NS * CMC_CLK_MHZ + 999) / 1000;
	localparam int CMC_TRIM_HIGH_CYC    = (CMC_TRIM_HIGH_NS * CMC_CLK_MHZ + 999) / 1000;
	localparam int CMC_WAIT_SHORT_CYC   = 1024;
	localparam int CMC_WAIT_LONG_CYC    = 65536;
	localparam int CMC_TRIM_RUN_CYC     = 2048;
	localparam int CMC_WAKE_CYC         = 256;
	localparam int CMC_CNT_W            = 20;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CMC_ST_WAIT = 2'b00,
		CMC_ST_IDLE = 2'b01,
		CMC_ST_RUN  = 2'b11
	} cmc_state_t;

	typedef struct packed {
		logic       interleave;
		logic       sample_q_src;
		logic       both_edges;
		logic       sleep_i;
		logic       sleep_q;
		logic       ready_i;
		logic       ready_q;
		logic       pattern;
		logic       ratio_1to1;
		logic       phase_90;
		logic       bias_on;
		logic [7:0] range_i;
		logic [7:0] range_q;
	} cmc_mode_t;
endpackage

// ---- verilog/cmc_sync.sv ----
// cmc_sync: two-flop synchroniser bank for static control pins
// assumes inputs asynchronous to i_core_clk
`timescale 1ns/10ps
module cmc_sync #(
	parameter int W = 1
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule

// ---- verilog/cmc_top.sv ----
// cmc_top: mode resolution, self-trim sequencing and output clock sync
// assumes apb master on i_core_clk and asynchronous control pins
//
// Contract
// - non-interleaved: each channel samples own input
// - pin mode interleaved: both channels use i
// - extended mode: bit 6 selects q source
// - extended mode: range from registers, pin ignored
// - interleaved: sample on both clock edges
// - sync pulse resets both output clocks
// - coupling pin high enables input bias
// - pin mode: interleave pin picks mode
// - extended mode: bit 7 interleave, resets off
// - wait pin picks long or short wait
// - trim after low then high minimum times
// - trigger high at power-on suppresses auto trim
// - extended mode: trigger pin ored with bit 1
// - trim-in-progress high exactly while trimming
// - sleep pin powers down, delayed wake
// - extended mode: sleep pin ored with bits
// - pin mode: pattern pin enables test pattern
// - extended mode: pattern only from bit 12
// - ratio pin selects 1:1 or 1:2
// - phase matters only in 1:2 output
// - extended mode: phase from bit 14
// - enable pin low selects extended mode, else defaults
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module cmc_top
	import cmc_pkg::*;
#(
	parameter int WAIT_SHORT_CYC = CMC_WAIT_SHORT_CYC,
	parameter int WAIT_LONG_CYC  = CMC_WAIT_LONG_CYC,
	parameter int TRIM_RUN_CYC   = CMC_TRIM_RUN_CYC,
	parameter int WAKE_CYC       = CMC_WAKE_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic      [31:0] o_prdata,
	output logic             o_pslverr,
	input  wire logic        i_extended_control_enable_n,
	input  wire logic        i_interleave_pin,
	input  wire logic        i_range_select_pin,
	input  wire logic        i_trim_wait_select,
	input  wire logic        i_trim_trigger,
	input  wire logic        i_sleep_chan_i,
	input  wire logic        i_sleep_chan_q,
	input  wire logic        i_pattern_mode_select,
	input  wire logic        i_output_ratio_select,
	input  wire logic        i_output_phase_select,
	input  wire logic        i_coupling_low,
	input  wire logic        i_out_clock_sync_pulse,
	output cmc_mode_t        o_mode,
	output logic             o_extended_control_mode,
	output logic             o_trim_in_progress,
	output logic             o_out_clock_i,
	output logic             o_out_clock_q
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [11:0] pins;
	logic ecm_n, p_il, p_rng, p_wait, p_trig, p_sli, p_slq, p_pat, p_rat, p_ph, p_cpl, p_sync;

	cmc_sync #(.W(12)) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_async    ({i_extended_control_enable_n, i_interleave_pin, i_range_select_pin,
		              i_trim_wait_select, i_trim_trigger, i_sleep_chan_i, i_sleep_chan_q,
		              i_pattern_mode_select, i_output_ratio_select, i_output_phase_select,
		              i_coupling_low, i_out_clock_sync_pulse}),
		.o_sync     (pins)
	);
	assign {ecm_n, p_il, p_rng, p_wait, p_trig, p_sli, p_slq, p_pat, p_rat, p_ph, p_cpl,
	        p_sync} = pins;

	logic extended_control_mode;
	assign extended_control_mode = ~ecm_n;

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	logic [31:0] config_reg;
	logic [7:0]  range_i_reg;
	logic [7:0]  range_q_reg;
	logic        wr_en;
	logic        rd_en;
	logic        trig_armed;

	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a == CMC_OFS_CONFIG) || (a == CMC_OFS_RANGE_I) ||
		          (a == CMC_OFS_RANGE_Q) || (a == CMC_OFS_STATUS);
	endfunction

	assign o_pready  = 1'b1;
	assign wr_en     = i_psel & i_penable & i_pwrite;
	assign rd_en     = i_psel & ~i_penable & ~i_pwrite;
	assign o_pslverr = i_psel & i_penable & (~addr_ok(i_paddr) | (i_pwrite & ~extended_control_mode));

	// registers return to defaults and refuse writes outside extended mode
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			config_reg  <= CMC_CONFIG_RESET;
			range_i_reg <= CMC_RANGE_RESET;
			range_q_reg <= CMC_RANGE_RESET;
		end else if (!extended_control_mode) begin
			config_reg  <= CMC_CONFIG_RESET;
			range_i_reg <= CMC_RANGE_RESET;
			range_q_reg <= CMC_RANGE_RESET;
		end else if (wr_en) begin
			if (i_paddr == CMC_OFS_CONFIG)
				config_reg <= i_pwdata & CMC_CONFIG_MASK;
			if (i_paddr == CMC_OFS_RANGE_I)
				range_i_reg <= i_pwdata[7:0];
			if (i_paddr == CMC_OFS_RANGE_Q)
				range_q_reg <= i_pwdata[7:0];
		end
	end

	// read data registered in setup, valid in access phase
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			case (i_paddr)
				CMC_OFS_CONFIG:  o_prdata <= config_reg;
				CMC_OFS_RANGE_I: o_prdata <= {24'h00_0000, range_i_reg};
				CMC_OFS_RANGE_Q: o_prdata <= {24'h00_0000, range_q_reg};
				CMC_OFS_STATUS:  o_prdata <= {26'h000_0000, o_mode.ready_q, o_mode.ready_i,
				                              o_mode.interleave, extended_control_mode, trig_armed,
				                              o_trim_in_progress};
				default:         o_prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// self-trim sequencer
	// ----------------------------------------------------------------
	cmc_state_t            state;
	logic [CMC_CNT_W-1:0]  cnt;
	logic [7:0]            low_cnt;
	logic [7:0]            high_cnt;
	logic                  trig;
	logic [1:0]            boot;
	logic                  low_met;
	logic                  inhibit;
	logic                  started;
	logic                  cmd_fire;

	assign trig     = p_trig | (extended_control_mode & config_reg[CMC_BIT_TRIM]);
	assign low_met  = (low_cnt >= 8'(CMC_TRIM_LOW_CYC));
	assign cmd_fire = trig_armed & (high_cnt >= 8'(CMC_TRIM_HIGH_CYC));

	// low then high timing of the trigger
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			low_cnt    <= 8'h00;
			high_cnt   <= 8'h00;
			trig_armed <= 1'b0;
		end else if (!trig) begin
			high_cnt   <= 8'h00;
			trig_armed <= 1'b0;
			if (!low_met)
				low_cnt <= low_cnt + 8'h01;
		end else begin
			if (low_met)
				trig_armed <= 1'b1;
			low_cnt <= 8'h00;
			if (cmd_fire)
				trig_armed <= 1'b0;
			else if (trig_armed && high_cnt < 8'hff)
				high_cnt <= high_cnt + 8'h01;
		end
	end

	// power-on trim held off while trigger high from the start
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			boot    <= 2'b00;
			started <= 1'b0;
			inhibit <= 1'b0;
		end else begin
			// wait out synchroniser latency before sampling the pin
			boot <= {boot[0], 1'b1};
			if (boot[1])
				started <= 1'b1;
			if (boot[1] && !started)
				inhibit <= p_trig;
			else if (started && !trig)
				inhibit <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= CMC_ST_WAIT;
			cnt   <= '0;
		end else begin
			case (state)
				CMC_ST_WAIT: begin
					if (cmd_fire) begin
						state <= CMC_ST_RUN;
						cnt   <= '0;
					end else if (started && !inhibit && !p_trig) begin
						if (cnt >= CMC_CNT_W'(p_wait ? WAIT_LONG_CYC : WAIT_SHORT_CYC)) begin
							state <= CMC_ST_RUN;
							cnt   <= '0;
						end else begin
							cnt <= cnt + 1'b1;
						end
					end
				end
				CMC_ST_RUN: begin
					if (cnt >= CMC_CNT_W'(TRIM_RUN_CYC - 1)) begin
						state <= CMC_ST_IDLE;
						cnt   <= '0;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
				CMC_ST_IDLE: begin
					if (cmd_fire)
						state <= CMC_ST_RUN;
				end
				default: state <= CMC_ST_WAIT;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_trim_in_progress <= 1'b0;
		else
			o_trim_in_progress <= (state == CMC_ST_RUN);
	end

	// ----------------------------------------------------------------
	// channel sleep with delayed wake
	// ----------------------------------------------------------------
	logic [1:0] sleep_req;
	logic [1:0] ready;
	assign sleep_req[0] = p_sli | (extended_control_mode & config_reg[CMC_BIT_SLEEP_I]);
	assign sleep_req[1] = p_slq | (extended_control_mode & config_reg[CMC_BIT_SLEEP_Q]);

	for (genvar c = 0; c < 2; c++) begin : g_wake
		logic [15:0] wcnt;
		always_ff @(posedge i_core_clk or posedge i_rst) begin
			if (i_rst) begin
				wcnt     <= 16'h0000;
				ready[c] <= 1'b0;
			end else if (sleep_req[c]) begin
				wcnt     <= 16'h0000;
				ready[c] <= 1'b0;
			end else if (wcnt >= 16'(WAKE_CYC - 1)) begin
				ready[c] <= 1'b1;
			end else begin
				wcnt <= wcnt + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// mode resolution
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mode                  <= '0;
			o_extended_control_mode <= 1'b0;
		end else begin
			o_extended_control_mode <= extended_control_mode;
			o_mode.interleave   <= extended_control_mode ? config_reg[CMC_BIT_INTERLEAVE] : p_il;
			o_mode.both_edges   <= extended_control_mode ? config_reg[CMC_BIT_INTERLEAVE] : p_il;
			o_mode.sample_q_src <= extended_control_mode & config_reg[CMC_BIT_INTERLEAVE] &
			                       config_reg[CMC_BIT_ALT_INPUT];
			o_mode.range_i      <= extended_control_mode ? range_i_reg : CMC_RANGE_MIN;
			o_mode.range_q      <= extended_control_mode ? range_q_reg : CMC_RANGE_MIN;
			o_mode.sleep_i      <= sleep_req[0];
			o_mode.sleep_q      <= sleep_req[1];
			o_mode.ready_i      <= ready[0];
			o_mode.ready_q      <= ready[1];
			o_mode.pattern      <= extended_control_mode ? config_reg[CMC_BIT_PATTERN] : p_pat;
			o_mode.ratio_1to1   <= p_rat;
			o_mode.phase_90     <= ~p_rat & (extended_control_mode ? config_reg[CMC_BIT_PHASE] : p_ph);
			o_mode.bias_on      <= p_cpl;
		end
	end

	// ----------------------------------------------------------------
	// output data clocks, divide by 2 or 4 of core clock
	// ----------------------------------------------------------------
	logic [1:0] dclk_cnt;
	logic       sync_d;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			dclk_cnt <= 2'b00;
			sync_d   <= 1'b0;
		end else begin
			sync_d <= p_sync;
			if (p_sync && !sync_d)
				dclk_cnt <= 2'b00;
			else
				dclk_cnt <= dclk_cnt + 2'b01;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_out_clock_i <= 1'b0;
			o_out_clock_q <= 1'b0;
		end else begin
			o_out_clock_i <= ready[0] & (p_rat ? dclk_cnt[0] : dclk_cnt[1]);
			o_out_clock_q <= ready[1] & (p_rat ? dclk_cnt[0] : dclk_cnt[1]);
		end
	end
endmodule

// ---- verification/cmc_host_model.sv ----
// cmc_host_model: host driving trim trigger, range and sync pins
// assumes the core clock of cmc_top; not reset with the device
`timescale 1ns/10ps
module cmc_host_model #(
	parameter int HOLD = 10
) (
	input  wire logic i_core_clk,
	input  wire logic i_trig_req,
	input  wire logic i_sync_req,
	output logic      o_trig,
	output logic      o_range,
	output logic      o_sync
);
	int cnt;
	initial begin
		cnt = 0;
		o_trig = 1'h0;
		o_sync = 1'h0;
	end
	// range pin held high for pin control
	assign o_range = 1'h1;
	// trigger level changes only after hold cycles at the old level
	always @(posedge i_core_clk) begin
		if (cnt != 0)
			cnt <= cnt - 1;
		else if (o_trig !== i_trig_req) begin
			o_trig <= i_trig_req;
			cnt <= HOLD;
		end
	end
	// sync pulse launched on the clock edge
	always @(posedge i_core_clk) begin
		o_sync <= i_sync_req;
	end
endmodule

// ---- verification/cmc_top_assertions.sv ----
// cmc_top_assertions: mode, bus and trim checks on cmc_top ports
// assumes bind into cmc_top
`timescale 1ns/10ps
module cmc_top_assertions
	import cmc_pkg::*;
#(
	parameter int TRIM_RUN_CYC = CMC_TRIM_RUN_CYC
) (
	input wire logic      i_core_clk,
	input wire logic      i_rst,
	input wire logic      i_psel,
	input wire logic      i_penable,
	input wire logic      i_pwrite,
	input wire logic      o_pslverr,
	input wire logic      i_extended_control_enable_n,
	input wire logic      i_interleave_pin,
	input wire logic      i_sleep_chan_i,
	input wire logic      i_pattern_mode_select,
	input wire logic      i_output_ratio_select,
	input wire logic      i_output_phase_select,
	input wire logic      i_coupling_low,
	input wire cmc_mode_t o_mode,
	input wire logic      o_extended_control_mode,
	input wire logic      o_trim_in_progress
);
	logic [6:0]  pins;
	logic [15:0] run_cnt;
	assign pins = {i_extended_control_enable_n, i_interleave_pin, i_sleep_chan_i,
		i_pattern_mode_select, i_output_ratio_select, i_output_phase_select, i_coupling_low};
	// length of the current trim run
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			run_cnt <= '0;
		else if (o_trim_in_progress)
			run_cnt <= run_cnt + 16'h1;
		else
			run_cnt <= '0;
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	sequence quiet;
		$stable(pins) [*5];
	endsequence
	sequence pin_mode;
		quiet ##0 !o_extended_control_mode;
	endsequence
	a_ecm_follows: assert property (quiet |-> o_extended_control_mode == !i_extended_control_enable_n)
		else $error("extended mode does not follow its pin");
	a_pin_interleave: assert property (pin_mode |-> o_mode.interleave == i_interleave_pin)
		else $error("interleave does not follow its pin");
	a_edges_follow: assert property (quiet |-> o_mode.both_edges == o_mode.interleave)
		else $error("dual edge sampling differs from interleave");
	a_q_src_gate: assert property (pin_mode |-> !o_mode.sample_q_src)
		else $error("q source chosen under pin control");
	a_pin_pattern: assert property (pin_mode |-> o_mode.pattern == i_pattern_mode_select)
		else $error("pattern does not follow its pin");
	a_ratio_pin: assert property (quiet |-> o_mode.ratio_1to1 == i_output_ratio_select)
		else $error("output ratio does not follow its pin");
	a_phase_1to1: assert property (quiet ##0 o_mode.ratio_1to1 |-> !o_mode.phase_90)
		else $error("phase set in undivided output");
	a_pin_phase: assert property (pin_mode ##0 !i_output_ratio_select
		|-> o_mode.phase_90 == i_output_phase_select)
		else $error("phase does not follow its pin");
	a_sleep_pin: assert property (quiet ##0 i_sleep_chan_i |-> o_mode.sleep_i && !o_mode.ready_i)
		else $error("channel awake with sleep pin high");
	a_bias_pin: assert property (quiet |-> o_mode.bias_on == i_coupling_low)
		else $error("bias does not follow coupling pin");
	a_write_refused: assert property (quiet ##0 i_psel && i_penable && i_pwrite &&
		!o_extended_control_mode |-> o_pslverr)
		else $error("write accepted under pin control");
	a_trim_length: assert property ($fell(o_trim_in_progress) |-> run_cnt == TRIM_RUN_CYC)
		else $error("trim run has wrong length");
endmodule
bind cmc_top cmc_top_assertions #(.TRIM_RUN_CYC(TRIM_RUN_CYC)) u_chk (.i_core_clk, .i_rst,
	.i_psel, .i_penable, .i_pwrite, .o_pslverr, .i_extended_control_enable_n,
	.i_interleave_pin, .i_sleep_chan_i, .i_pattern_mode_select, .i_output_ratio_select,
	.i_output_phase_select, .i_coupling_low, .o_mode, .o_extended_control_mode,
	.o_trim_in_progress);

// ---- verification/tb_converter_mode_control.sv ----
// tb_converter_mode_control: self-checking bench for cmc_top
// assumes cmc_host_model on trigger, range and sync pins
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin errors++; \
	$display("MISMATCH %s exp=%h got=%h", n, e, s); end end
module tb_converter_mode_control
	import cmc_pkg::*;
;
	localparam int WS = 16;
	localparam int WL = 32;
	localparam int TR = 20;
	logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	logic        ecm_n = 1'h1, wsel = 1'h0, trq = 1'h0, srq = 1'h0;
	logic [11:0] addr = '0;
	logic [31:0] wd = '0, rd, prd, cfg;
	logic [6:0]  pins = '0;
	logic [7:0]  ri, rq;
	logic        er, pre, perr, trig, rng, sync, eco, trim, ck_i, ck_q;
	cmc_mode_t   mode;
	int          errors = 0, checks_done = 0, t, len;
	always #5 clk = ~clk;
	cmc_top #(.WAIT_SHORT_CYC(WS), .WAIT_LONG_CYC(WL), .TRIM_RUN_CYC(TR), .WAKE_CYC(8)) dut (
		.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(addr), .i_pwdata(wd), .o_pready(pre), .o_prdata(prd), .o_pslverr(perr),
		.i_extended_control_enable_n(ecm_n), .i_interleave_pin(pins[0]),
		.i_range_select_pin(rng), .i_trim_wait_select(wsel), .i_trim_trigger(trig),
		.i_sleep_chan_i(pins[1]), .i_sleep_chan_q(pins[2]), .i_pattern_mode_select(pins[3]),
		.i_output_ratio_select(pins[4]), .i_output_phase_select(pins[5]),
		.i_coupling_low(pins[6]), .i_out_clock_sync_pulse(sync), .o_mode(mode),
		.o_extended_control_mode(eco), .o_trim_in_progress(trim), .o_out_clock_i(ck_i),
		.o_out_clock_q(ck_q));
	cmc_host_model #(.HOLD(10)) host (.i_core_clk(clk), .i_trig_req(trq), .i_sync_req(srq),
		.o_trig(trig), .o_range(rng), .o_sync(sync));
	// ----------------------------------------------------------------
	// expectations and bus tasks
	// ----------------------------------------------------------------
	function automatic cmc_mode_t exp_mode(logic [6:0] p, logic e, logic [31:0] c,
		logic [7:0] ri, logic [7:0] rq);
		cmc_mode_t m;
		m.interleave = e ? c[7] : p[0];
		m.sample_q_src = e & c[7] & c[6];
		m.both_edges = m.interleave;
		m.sleep_i = p[1] | (e & c[11]);
		m.sleep_q = p[2] | (e & c[10]);
		m.ready_i = !m.sleep_i;
		m.ready_q = !m.sleep_q;
		m.pattern = e ? c[12] : p[3];
		m.ratio_1to1 = p[4];
		m.phase_90 = !p[4] & (e ? c[14] : p[5]);
		m.bias_on = p[6];
		m.range_i = e ? ri : CMC_RANGE_MIN;
		m.range_q = e ? rq : CMC_RANGE_MIN;
		return m;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic do_reset();
		rst <= 1'h1;
		cyc(8);
		rst <= 1'h0;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		addr <= a;
		wd <= d;
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pre !== 1'h1 && n < 20);
		rd = prd;
		er = perr;
		psel <= 1'h0;
		pen <= 1'h0;
		if (n >= 20) errors++;
	endtask
	task automatic trim_run(input int lim);
		t = 0;
		len = 0;
		while (trim !== 1'h1 && t < lim) begin
			@(posedge clk);
			t++;
		end
		while (trim === 1'h1 && len < 100) begin
			@(posedge clk);
			len++;
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		errors++;
		final_report();
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h9f28));
		for (int w = 0; w < 2; w++) begin
			wsel <= w[0];
			do_reset();
			trim_run(200);
			`CHK("trim start", 1'h1, t >= (w ? WL : WS) && t < (w ? WL : WS) + 10)
			`CHK("trim length", TR, len)
		end
		trq <= 1'h1;
		cyc(12);
		do_reset();
		trim_run(80);
		`CHK("trim inhibited", 0, len)
		trq <= 1'h0;
		cyc(12);
		trq <= 1'h1;
		trim_run(60);
		`CHK("trim on command", TR, len)
		srq <= 1'h1;
		cyc(3);
		srq <= 1'h0;
		cyc(12);
		`CHK("clocks aligned", ck_i, ck_q)
		for (int k = 0; k < 24; k++) begin
			pins <= k ? 7'($urandom) : 7'h7f;
			cyc(16);
			`CHK("pin mode", exp_mode(pins, 1'h0, '0, '0, '0), mode)
			apb(1'h1, CMC_OFS_CONFIG, 32'h0000_0080);
			`CHK("write refused", 1'h1, er)
		end
		ecm_n <= 1'h0;
		cyc(6);
		for (int k = 0; k < 16; k++) begin
			cfg = (k ? $urandom : 32'hffff_ffff) & CMC_CONFIG_MASK & 32'hffff_fffd;
			ri = 8'($urandom);
			rq = 8'($urandom);
			pins <= 7'($urandom);
			apb(1'h1, CMC_OFS_CONFIG, cfg);
			apb(1'h1, CMC_OFS_RANGE_I, {24'h0, ri});
			apb(1'h1, CMC_OFS_RANGE_Q, {24'h0, rq});
			apb(1'h0, CMC_OFS_CONFIG, '0);
			`CHK("config", cfg, rd)
			cyc(16);
			`CHK("ecm mode", exp_mode(pins, 1'h1, cfg, ri, rq), mode)
		end
		trq <= 1'h0;
		cyc(12);
		apb(1'h1, CMC_OFS_CONFIG, 32'h0000_0002);
		trim_run(60);
		`CHK("trim by bit", TR, len)
		apb(1'h0, 12'h010, '0);
		`CHK("unmapped err", 1'h1, er)
		`CHK("unmapped data", 32'h0, rd)
		ecm_n <= 1'h1;
		cyc(6);
		apb(1'h1, CMC_OFS_CONFIG, 32'h0000_4000);
		`CHK("pin write err", 1'h1, er)
		ecm_n <= 1'h0;
		cyc(6);
		apb(1'h0, CMC_OFS_CONFIG, '0);
		`CHK("config default", CMC_CONFIG_RESET, rd)
		final_report();
	end
endmodule
